// [rtl/efcc_link_if.sv]
// Signals shared between the sequencer, zone checker and time base.
`timescale 1ns/10ps
interface efcc_link_if;
  logic [16:0] addr;
  logic op_wr;
  logic op_er;
  logic op_ifb;
  logic writer;
  logic [7:0] loz;
  logic [7:0] hiz;
  logic [7:0] scaler;
  logic tick;
  logic hit;
  modport core (output addr, op_wr, op_er, op_ifb, writer, loz, hiz,
    scaler, input tick, hit);
  modport chk (input addr, op_wr, op_er, op_ifb, writer, loz, hiz,
    output hit);
  modport tb (input scaler, output tick);
endinterface

// [rtl/efcc_pkg.sv]
// Constants, register map and state codes of the flash command controller.
package efcc_pkg;
  // ==========================================================
  // Register offsets on the extended function register port
  localparam logic [15:0] OFS_CMD = 16'hA020;
  localparam logic [15:0] OFS_DAT = 16'hA021;
  localparam logic [15:0] OFS_ADH = 16'hA022;
  localparam logic [15:0] OFS_ADL = 16'hA023;
  localparam logic [15:0] OFS_SCL = 16'hA024;
  localparam logic [15:0] OFS_LOZ = 16'hA025;
  localparam logic [15:0] OFS_HIZ = 16'hA026;
  localparam logic [15:0] OFS_ADM = 16'hA012;
  // ==========================================================
  // Reset values
  localparam logic [7:0] RST_CMD = 8'h80;
  localparam logic [7:0] RST_DAT = 8'h00;
  localparam logic [7:0] RST_ADR = 8'h00;
  localparam logic [7:0] RST_SCL = 8'h25;
  localparam logic [7:0] RST_LOZ = 8'hFF;
  localparam logic [7:0] RST_HIZ = 8'h00;
  // Fixed ones in the read view of the bit-16 address register.
  localparam logic [7:0] ADM_RD_ONES = 8'h3C;
  // ==========================================================
  // Field positions of the command and status register
  localparam int VFY_BIT = 7;
  localparam int BUSY_BIT = 6;
  localparam int FAIL_BIT = 5;
  localparam int CYC_MSB = 7;
  localparam int CYC_LSB = 5;
  localparam int CODE_MSB = 4;
  // ==========================================================
  // Command codes
  localparam logic [4:0] CMD_MAIN_RD = 5'h10;
  localparam logic [4:0] CMD_MAIN_ER = 5'h08;
  localparam logic [4:0] CMD_MAIN_WR = 5'h04;
  localparam logic [4:0] CMD_IFB_RD = 5'h02;
  localparam logic [4:0] CMD_IFB_WR = 5'h01;
  // ==========================================================
  // Array geometry
  localparam int ADDR_W = 17;
  localparam int SECTOR_BYTES = 1024;
  localparam int SECT_LSB = $clog2(SECTOR_BYTES);
  localparam int ZONE_LSB = 9;
  localparam int IFB_BYTES = 256;
  localparam int IFB_AW = $clog2(IFB_BYTES);
  localparam logic [7:0] IFB_RSV_FIRST = 8'hF0;
  // ==========================================================
  // Timeouts in command time base cycles
  localparam int CNT_W = 14;
  localparam logic [13:0] TO_WRITE [8] = '{14'h0037, 14'h003C,
    14'h0041, 14'h0045, 14'h004B, 14'h0050, 14'h0055, 14'h0059};
  localparam logic [13:0] TO_ERASE [8] = '{14'h153B, 14'h1741,
    14'h1934, 14'h1AF1, 14'h1CF0, 14'h1EE2, 14'h20D4, 14'h22B9};
  // ==========================================================
  // Sequencer states, Gray coded from idle to finish along the write path
  typedef enum logic [2:0] {
    ST_IDLE = 3'h0,
    ST_CHECK = 3'h1,
    ST_ACCESS = 3'h3,
    ST_VERIFY = 3'h2,
    ST_FINISH = 3'h6
  } efcc_state_t;
endpackage

// [rtl/efcc_time_base.sv]
// Command time base: fractional divider of the system clock.
`timescale 1ns/10ps
module efcc_time_base (
  // Clock and reset
  input wire logic mclk_i,
  input wire logic rst_n_i,
  // Shared signals
  efcc_link_if.tb lk
);
  logic [7:0] acc_q;
  logic tick_q;
  wire [8:0] sum = {1'b0, acc_q} + {1'b0, lk.scaler} + 9'h001;

  // ==========================================================
  // Phase accumulator
  // [RQ11] carry rate n+1 over 256
  always_ff @(posedge mclk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      acc_q <= 8'h00;
      tick_q <= 1'b0;
    end
    else
    begin
      acc_q <= sum[7:0];
      tick_q <= sum[8];
    end
  end
  assign lk.tick = tick_q;

  a_tick_full_rate: assert property (@(posedge mclk_i) // [RQ11]
    disable iff (!rst_n_i) lk.scaler == 8'hFF |=> lk.tick)
    else $error("tick missing at full rate");
  a_tick_spacing: assert property (@(posedge mclk_i) // [RQ23]
    disable iff (!rst_n_i) (lk.scaler == 8'h00)[*2] ##0 lk.tick
    |=> !lk.tick) else $error("ticks too close");
endmodule

// [rtl/efcc_top.sv]
// Flash command sequencer between the processor and the embedded flash.
`timescale 1ns/10ps
// Summary of operation
// [RQ1] Stall processor until the command completes
// [RQ2] Main array 128K bytes, 1024-byte sectors
// [RQ3] Separate 256-byte information block, own commands
// [RQ4] Read back each write, clear verify on mismatch
// [RQ5] Verify bit returns to one on start
// [RQ6] Busy bit set while command executes
// [RQ7] Fail bit sticky until next command
// [RQ8] Out-of-range or protected target fails
// [RQ9] Three-bit timeout select picks cycle table
// [RQ10] Software sets timeout select to 111
// [RQ11] Time base is clock times (n+1)/256
// [RQ12] Software picks scaler near 2 MHz
// [RQ13] Five-bit command code decodes five operations
// [RQ14] Invalid codes fail without executing
// [RQ15] Address from registers, data via data register
// [RQ16] Erase uses high address bits, whole sector
// [RQ17] Protected erase or write skipped, fails
// [RQ18] Reserved information bytes refuse writes
// [RQ19] Calibration area writable only in programmer mode
// [RQ20] Two zones bounded in 512-byte units
// [RQ21] Bounds reset to FF and 00
// [RQ22] Address from low, high and bit-16 registers
// [RQ23] Time base uses the multiply form
// [RQ24] Timeout ends command with fail
module efcc_top (
  // Clock and reset
  input wire logic mclk_i,
  input wire logic rst_n_i,
  // Extended function register port
  input wire logic [15:0] xfr_addr_i,
  input wire logic xfr_wr_i,
  input wire logic [7:0] xfr_wdata_i,
  output logic [7:0] xfr_rdata_o,
  // Processor stall
  output logic cpu_hold_o,
  // Programmer mode pin
  input wire logic writer_mode_i,
  // Flash macro port
  output logic [16:0] fl_addr_o,
  output logic [7:0] fl_wdata_o,
  output logic fl_rd_o,
  output logic fl_wr_o,
  output logic fl_er_o,
  output logic fl_ifb_o,
  input wire logic [7:0] fl_rdata_i,
  input wire logic fl_done_i
);
  function automatic logic at(input logic [15:0] a, input logic [15:0] o);
    return a == o;
  endfunction

  // ==========================================================
  // Reset release and pin synchronisers
  logic [1:0] rst_sync_q;
  logic [1:0] wm_sync_q;
  wire rst_n = rst_sync_q[1];
  always_ff @(posedge mclk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      rst_sync_q <= 2'h0;
    else
      rst_sync_q <= {rst_sync_q[0], 1'b1};
  end
  always_ff @(posedge mclk_i or negedge rst_n)
  begin
    if (!rst_n)
      wm_sync_q <= 2'h0;
    else
      wm_sync_q <= {wm_sync_q[0], writer_mode_i};
  end

  // ==========================================================
  // Register state
  logic [7:0] dat_q, dat_d;
  logic [7:0] adl_q;
  logic [7:0] adh_q;
  logic a16_q;
  logic [7:0] scl_q;
  logic [7:0] loz_q;
  logic [7:0] hiz_q;
  logic [2:0] cyc_q;
  logic [4:0] code_q;
  logic vfy_q, vfy_d;
  logic fail_q, fail_d;
  logic busy_q;
  logic hold_q;
  logic [13:0] cnt_q, cnt_d;
  efcc_pkg::efcc_state_t state_q, state_d;
  logic rd_d, wr_d, er_d;
  logic [7:0] rdata_q;
  logic [16:0] fl_addr_q;
  logic [7:0] fl_wdata_q;
  logic fl_rd_q, fl_wr_q, fl_er_q, fl_ifb_q;

  // ==========================================================
  // Register port decode
  // Writes are ignored while busy, since the processor is stalled anyway.
  wire sw_wr = xfr_wr_i && !busy_q;
  wire wr_cmd = sw_wr && at(xfr_addr_i, efcc_pkg::OFS_CMD);
  wire wr_dat = sw_wr && at(xfr_addr_i, efcc_pkg::OFS_DAT);
  wire wr_adh = sw_wr && at(xfr_addr_i, efcc_pkg::OFS_ADH);
  wire wr_adl = sw_wr && at(xfr_addr_i, efcc_pkg::OFS_ADL);
  wire wr_adm = sw_wr && at(xfr_addr_i, efcc_pkg::OFS_ADM);
  wire wr_scl = sw_wr && at(xfr_addr_i, efcc_pkg::OFS_SCL);
  wire wr_loz = sw_wr && at(xfr_addr_i, efcc_pkg::OFS_LOZ);
  wire wr_hiz = sw_wr && at(xfr_addr_i, efcc_pkg::OFS_HIZ);

  // ==========================================================
  // Command decode
  // [RQ13] five valid codes
  wire is_main_rd = code_q == efcc_pkg::CMD_MAIN_RD;
  wire is_main_er = code_q == efcc_pkg::CMD_MAIN_ER;
  wire is_main_wr = code_q == efcc_pkg::CMD_MAIN_WR;
  wire is_ifb_rd = code_q == efcc_pkg::CMD_IFB_RD;
  wire is_ifb_wr = code_q == efcc_pkg::CMD_IFB_WR;
  wire is_rd = is_main_rd || is_ifb_rd;
  wire is_wr = is_main_wr || is_ifb_wr;
  wire is_er = is_main_er;
  // [RQ3] information block commands
  wire is_ifb = is_ifb_rd || is_ifb_wr;
  wire code_ok = is_rd || is_wr || is_er;

  // [RQ22] seventeen-bit address
  wire [16:0] addr = {a16_q, adh_q, adl_q};
  // [RQ2] [RQ16] erase targets the sector base
  wire [16:0] sec_base = {addr[16:efcc_pkg::SECT_LSB],
    {efcc_pkg::SECT_LSB{1'b0}}};
  wire [16:0] ifb_addr = {9'h000, addr[7:0]};
  wire [16:0] fl_addr_d = is_er ? sec_base : (is_ifb ? ifb_addr : addr);

  // [RQ9] timeout table chosen by operation
  wire [13:0] lim = is_er ? efcc_pkg::TO_ERASE[cyc_q] :
    efcc_pkg::TO_WRITE[cyc_q];
  // [RQ24] expiry of the timeout count
  wire timed_out = cnt_q >= lim;
  wire waiting = (state_q == efcc_pkg::ST_ACCESS) ||
    (state_q == efcc_pkg::ST_VERIFY);

  // ==========================================================
  // Links to the zone checker and the time base
  efcc_link_if lk ();
  assign lk.addr = addr;
  assign lk.op_wr = is_wr;
  assign lk.op_er = is_er;
  assign lk.op_ifb = is_ifb;
  assign lk.writer = wm_sync_q[1];
  assign lk.loz = loz_q;
  assign lk.hiz = hiz_q;
  // [RQ23] multiply form of the scaler
  assign lk.scaler = scl_q;

  efcc_zone_chk u_chk (
    .lk(lk.chk)
  );

  efcc_time_base u_tb (
    .mclk_i(mclk_i),
    .rst_n_i(rst_n),
    .lk(lk.tb)
  );

  // ==========================================================
  // Sequencer
  always_comb
  begin
    state_d = state_q;
    fail_d = fail_q;
    vfy_d = vfy_q;
    cnt_d = cnt_q;
    rd_d = 1'b0;
    wr_d = 1'b0;
    er_d = 1'b0;
    unique case (state_q)
      efcc_pkg::ST_IDLE:
        if (wr_cmd)
        begin
          // [RQ5] [RQ7] fresh status on every start
          state_d = efcc_pkg::ST_CHECK;
          fail_d = 1'b0;
          vfy_d = 1'b1;
          cnt_d = 14'h0000;
        end
      efcc_pkg::ST_CHECK:
        // [RQ14] [RQ8] [RQ17] refuse before any strobe
        if (!code_ok || lk.hit)
        begin
          fail_d = 1'b1;
          state_d = efcc_pkg::ST_FINISH;
        end
        else
        begin
          rd_d = is_rd;
          wr_d = is_wr;
          er_d = is_er;
          state_d = efcc_pkg::ST_ACCESS;
        end
      efcc_pkg::ST_ACCESS:
        if (fl_done_i && is_wr)
        begin
          // [RQ4] read the written byte back
          rd_d = 1'b1;
          state_d = efcc_pkg::ST_VERIFY;
        end
        else if (fl_done_i)
          state_d = efcc_pkg::ST_FINISH;
        else if (timed_out)
        begin
          fail_d = 1'b1;
          state_d = efcc_pkg::ST_FINISH;
        end
      efcc_pkg::ST_VERIFY:
        if (fl_done_i)
        begin
          // [RQ4] compare with the intended byte
          vfy_d = fl_rdata_i == dat_q;
          state_d = efcc_pkg::ST_FINISH;
        end
        else if (timed_out)
        begin
          fail_d = 1'b1;
          state_d = efcc_pkg::ST_FINISH;
        end
      efcc_pkg::ST_FINISH:
        state_d = efcc_pkg::ST_IDLE;
      default:
        state_d = efcc_pkg::ST_IDLE;
    endcase
    if (waiting && lk.tick && !timed_out)
      cnt_d = cnt_q + 14'h0001;
  end

  // [RQ15] read results land in the data register
  wire rd_done = (state_q == efcc_pkg::ST_ACCESS) && fl_done_i && is_rd;
  assign dat_d = rd_done ? fl_rdata_i : (wr_dat ? xfr_wdata_i : dat_q);
  wire leave_chk = rd_d || wr_d || er_d;

  always_ff @(posedge mclk_i or negedge rst_n)
  begin
    if (!rst_n)
    begin
      state_q <= efcc_pkg::ST_IDLE;
      fail_q <= efcc_pkg::RST_CMD[efcc_pkg::FAIL_BIT];
      vfy_q <= efcc_pkg::RST_CMD[efcc_pkg::VFY_BIT];
      busy_q <= efcc_pkg::RST_CMD[efcc_pkg::BUSY_BIT];
      hold_q <= 1'b0;
      cnt_q <= 14'h0000;
    end
    else
    begin
      state_q <= state_d;
      fail_q <= fail_d;
      vfy_q <= vfy_d;
      // [RQ6] [RQ1] busy and stall track the sequencer
      busy_q <= state_d != efcc_pkg::ST_IDLE;
      hold_q <= state_d != efcc_pkg::ST_IDLE;
      cnt_q <= cnt_d;
    end
  end

  // ==========================================================
  // Software registers
  always_ff @(posedge mclk_i or negedge rst_n)
  begin
    if (!rst_n)
    begin
      dat_q <= efcc_pkg::RST_DAT;
      adl_q <= efcc_pkg::RST_ADR;
      adh_q <= efcc_pkg::RST_ADR;
      a16_q <= 1'b0;
      scl_q <= efcc_pkg::RST_SCL;
      // [RQ21] whole array protected after reset
      loz_q <= efcc_pkg::RST_LOZ;
      hiz_q <= efcc_pkg::RST_HIZ;
      cyc_q <= efcc_pkg::RST_CMD[efcc_pkg::CYC_MSB:efcc_pkg::CYC_LSB];
      code_q <= efcc_pkg::RST_CMD[efcc_pkg::CODE_MSB:0];
    end
    else
    begin
      dat_q <= dat_d;
      adl_q <= wr_adl ? xfr_wdata_i : adl_q;
      adh_q <= wr_adh ? xfr_wdata_i : adh_q;
      a16_q <= wr_adm ? xfr_wdata_i[0] : a16_q;
      scl_q <= wr_scl ? xfr_wdata_i : scl_q;
      loz_q <= wr_loz ? xfr_wdata_i : loz_q;
      hiz_q <= wr_hiz ? xfr_wdata_i : hiz_q;
      cyc_q <= wr_cmd ? xfr_wdata_i[efcc_pkg::CYC_MSB:efcc_pkg::CYC_LSB] :
        cyc_q;
      code_q <= wr_cmd ? xfr_wdata_i[efcc_pkg::CODE_MSB:0] : code_q;
    end
  end

  // ==========================================================
  // Read view, registered one cycle after the address
  wire [7:0] stat = {vfy_q, busy_q, fail_q, code_q};
  wire [7:0] rd_mux =
    at(xfr_addr_i, efcc_pkg::OFS_CMD) ? stat :
    at(xfr_addr_i, efcc_pkg::OFS_DAT) ? dat_q :
    at(xfr_addr_i, efcc_pkg::OFS_ADH) ? adh_q :
    at(xfr_addr_i, efcc_pkg::OFS_ADL) ? adl_q :
    at(xfr_addr_i, efcc_pkg::OFS_ADM) ? (efcc_pkg::ADM_RD_ONES |
      {7'h00, a16_q}) :
    at(xfr_addr_i, efcc_pkg::OFS_SCL) ? scl_q :
    at(xfr_addr_i, efcc_pkg::OFS_LOZ) ? loz_q :
    at(xfr_addr_i, efcc_pkg::OFS_HIZ) ? hiz_q : 8'h00;

  // ==========================================================
  // Flash macro strobes, one cycle each
  always_ff @(posedge mclk_i or negedge rst_n)
  begin
    if (!rst_n)
    begin
      rdata_q <= 8'h00;
      fl_addr_q <= 17'h00000;
      fl_wdata_q <= 8'h00;
      fl_rd_q <= 1'b0;
      fl_wr_q <= 1'b0;
      fl_er_q <= 1'b0;
      fl_ifb_q <= 1'b0;
    end
    else
    begin
      rdata_q <= rd_mux;
      fl_addr_q <= leave_chk ? fl_addr_d : fl_addr_q;
      fl_wdata_q <= leave_chk ? dat_q : fl_wdata_q;
      fl_ifb_q <= leave_chk ? is_ifb : fl_ifb_q;
      fl_rd_q <= rd_d;
      fl_wr_q <= wr_d;
      fl_er_q <= er_d;
    end
  end

  assign xfr_rdata_o = rdata_q;
  assign cpu_hold_o = hold_q;
  assign fl_addr_o = fl_addr_q;
  assign fl_wdata_o = fl_wdata_q;
  assign fl_rd_o = fl_rd_q;
  assign fl_wr_o = fl_wr_q;
  assign fl_er_o = fl_er_q;
  assign fl_ifb_o = fl_ifb_q;

  // ==========================================================
  // Checks
  a_hold_on_start: assert property (@(posedge mclk_i) // [RQ1]
    disable iff (!rst_n) wr_cmd |=> cpu_hold_o && busy_q)
    else $error("no stall on start");
  a_hold_release: assert property (@(posedge mclk_i) // [RQ6]
    disable iff (!rst_n) state_q == efcc_pkg::ST_FINISH |=>
    !cpu_hold_o && !busy_q) else $error("stall not released");
  a_start_status: assert property (@(posedge mclk_i) // [RQ5]
    disable iff (!rst_n) wr_cmd |=> vfy_q && !fail_q)
    else $error("status not renewed");
  a_fail_sticky: assert property (@(posedge mclk_i) // [RQ7]
    disable iff (!rst_n) fail_q && !wr_cmd |=> fail_q)
    else $error("fail lost");
  a_bad_code: assert property (@(posedge mclk_i) // [RQ14]
    disable iff (!rst_n) state_q == efcc_pkg::ST_CHECK && !code_ok |=>
    fail_q && !fl_rd_o && !fl_wr_o && !fl_er_o)
    else $error("invalid code ran");
  a_zone_skip: assert property (@(posedge mclk_i) // [RQ17]
    disable iff (!rst_n) state_q == efcc_pkg::ST_CHECK && lk.hit |=>
    fail_q && !fl_wr_o && !fl_er_o ##1 !busy_q)
    else $error("protected target touched");
  a_verify_miss: assert property (@(posedge mclk_i) // [RQ4]
    disable iff (!rst_n) state_q == efcc_pkg::ST_VERIFY && fl_done_i &&
    fl_rdata_i != dat_q |=> !vfy_q) else $error("mismatch not flagged");
  a_timeout_end: assert property (@(posedge mclk_i) // [RQ24]
    disable iff (!rst_n) waiting && timed_out && !fl_done_i |=>
    fail_q ##1 !cpu_hold_o) else $error("timeout not ended");
endmodule

// [rtl/efcc_zone_chk.sv]
// Address range and protection zone checker for flash commands.
`timescale 1ns/10ps
module efcc_zone_chk (
  // Shared signals
  efcc_link_if.chk lk
);
  function automatic logic zone_prot(input logic [7:0] u,
    input logic [7:0] lo, input logic [7:0] hi);
    return (u < lo) || (u > hi);
  endfunction

  // ==========================================================
  // Zone units of 512 bytes
  // [RQ20] low and high protection zones
  wire [7:0] unit = lk.addr[16:efcc_pkg::ZONE_LSB];
  wire [7:0] sec_lo = {lk.addr[16:efcc_pkg::SECT_LSB], 1'b0};
  wire [7:0] sec_hi = {lk.addr[16:efcc_pkg::SECT_LSB], 1'b1};
  // [RQ16] an erase covers both zone units of its sector
  wire er_hit = zone_prot(sec_lo, lk.loz, lk.hiz) ||
    zone_prot(sec_hi, lk.loz, lk.hiz);
  wire wr_hit = zone_prot(unit, lk.loz, lk.hiz);
  // [RQ17] protection applies to erase and write only
  wire main_hit = lk.op_er ? er_hit : (lk.op_wr && wr_hit);
  // [RQ8] information block beyond its size is out of range
  wire ifb_oor = lk.addr[16:efcc_pkg::IFB_AW] != 9'h000;
  // [RQ18] reserved bytes, [RQ19] open only in programmer mode
  wire ifb_rsv = (lk.addr[7:0] >= efcc_pkg::IFB_RSV_FIRST) && !lk.writer;
  wire ifb_hit = ifb_oor || (lk.op_wr && ifb_rsv);

  assign lk.hit = lk.op_ifb ? ifb_hit : main_hit;
endmodule

// [verif/efcc_flash_model.sv]
// Behavioural model of the embedded flash macro behind the controller.
`timescale 1ns/10ps
module efcc_flash_model (
  // Clock
  input wire logic mclk_i,
  // Macro request
  input wire logic [16:0] addr_i,
  input wire logic [7:0] wdata_i,
  input wire logic rd_i,
  input wire logic wr_i,
  input wire logic er_i,
  input wire logic ifb_i,
  // Test controls: latency, no answer, corrupt writes
  input wire logic [7:0] lat_i,
  input wire logic mute_i,
  input wire logic flip_i,
  // Macro answer
  output logic [7:0] rdata_o,
  output logic done_o
);
  logic [7:0] mem [logic [17:0]];
  logic [17:0] k;
  logic [7:0] d;
  initial
  begin
    done_o = 1'b0;
    rdata_o = 8'hA5;
    forever
    begin
      // Strobes are sampled mid-cycle so the edge that launches them is safe.
      @(negedge mclk_i);
      if ((rd_i | wr_i | er_i) === 1'b1)
      begin
        k = {ifb_i, addr_i};
        d = mem.exists(k) ? mem[k] : 8'hFF;
        if (wr_i)
          mem[k] = flip_i ? ~wdata_i : wdata_i;
        if (er_i)
          for (int i = 0; i < 1024; i++)
            mem.delete({1'b0, addr_i[16:10], 10'(i)});
        repeat (lat_i) @(posedge mclk_i);
        if (!mute_i)
        begin
          #1 done_o = 1'b1;
          rdata_o = d;
          @(posedge mclk_i);
          #1 done_o = 1'b0;
          // Stale data is inverted so a late sample cannot pass by luck.
          rdata_o = ~d;
        end
      end
    end
  end
endmodule

// [verif/embedded_flash_command_controller_tb.sv]
// Self-checking testbench of the flash command controller.
`timescale 1ns/10ps
module embedded_flash_command_controller_tb;
  logic mclk_i = 1'b0;
  logic rst_n_i = 1'b0;
  logic [15:0] xa = 16'h0000;
  logic xw = 1'b0;
  logic [7:0] xd = 8'h00;
  logic [7:0] xr;
  logic hold, wm = 1'b0, frd, fwr, fer, fifb, done, mute = 1'b0, flip = 1'b0;
  logic [16:0] fa;
  logic [7:0] fwd, frdat, lat = 8'h06, st, v;
  logic [16:0] s_addr;
  logic [7:0] s_dat;
  int fails = 0, n_checks = 0, n_str = 0, hold_n = 0;
  always #50 mclk_i = ~mclk_i;
  efcc_top u_efcc_top (.mclk_i(mclk_i), .rst_n_i(rst_n_i),
    .xfr_addr_i(xa), .xfr_wr_i(xw), .xfr_wdata_i(xd), .xfr_rdata_o(xr),
    .cpu_hold_o(hold), .writer_mode_i(wm), .fl_addr_o(fa),
    .fl_wdata_o(fwd), .fl_rd_o(frd), .fl_wr_o(fwr), .fl_er_o(fer),
    .fl_ifb_o(fifb), .fl_rdata_i(frdat), .fl_done_i(done));
  efcc_flash_model u_efcc_flash_model (.mclk_i(mclk_i), .addr_i(fa),
    .wdata_i(fwd), .rd_i(frd), .wr_i(fwr), .er_i(fer), .ifb_i(fifb),
    .lat_i(lat), .mute_i(mute), .flip_i(flip), .rdata_o(frdat),
    .done_o(done));
  always @(negedge mclk_i)
  begin
    if ((frd | fwr | fer) === 1'b1)
    begin
      n_str++;
      s_addr = fa;
      s_dat = fwd;
    end
  end
  always @(posedge mclk_i)
    if (hold === 1'b1)
      hold_n <= hold_n + 1;
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp)
    begin
      fails++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    @(negedge mclk_i);
    xa = a;
    xd = d;
    xw = 1'b1;
    @(negedge mclk_i);
    xw = 1'b0;
  endtask
  task automatic rd(input logic [15:0] a, output logic [7:0] d);
    @(negedge mclk_i);
    xa = a;
    @(negedge mclk_i);
    d = xr;
  endtask
  task automatic adr(input logic [16:0] a);
    wr(efcc_pkg::OFS_ADM, {7'h00, a[16]});
    wr(efcc_pkg::OFS_ADH, a[15:8]);
    wr(efcc_pkg::OFS_ADL, a[7:0]);
  endtask
  task automatic fin(input logic [7:0] exp, input logic [7:0] m);
    int n;
    n = 0;
    @(negedge mclk_i);
    while (hold !== 1'b0 && n < 20000)
    begin
      @(negedge mclk_i);
      n++;
    end
    check(hold, 1'b0);
    rd(efcc_pkg::OFS_CMD, st);
    check(st & m, exp);
  endtask
  task automatic cmd(input logic [7:0] c, input logic [7:0] e,
    input logic [7:0] m);
    hold_n = 0;
    wr(efcc_pkg::OFS_CMD, c);
    fin(e, m);
  endtask
  task automatic t_reset();
    logic [15:0] ra [7] = '{16'hA020, 16'hA021, 16'hA024, 16'hA025,
      16'hA026, 16'hA012, 16'hA030};
    logic [7:0] rv [7] = '{8'h80, 8'h00, 8'h25, 8'hFF, 8'h00, 8'h3C, 8'h00};
    for (int i = 0; i < 7; i++)
    begin
      rd(ra[i], v);
      check(v, rv[i]);
    end
    adr(17'h00400);
    n_str = 0;
    cmd(8'hE4, 8'hA4, 8'hFF);
    check(n_str, 0);
    $display("test reset done");
  endtask
  task automatic t_write();
    wr(efcc_pkg::OFS_LOZ, 8'h00);
    wr(efcc_pkg::OFS_HIZ, 8'hFF);
    // one tick per clock keeps the runs short
    wr(efcc_pkg::OFS_SCL, 8'hFF);
    adr(17'h1ABCD);
    wr(efcc_pkg::OFS_DAT, 8'h5A);
    n_str = 0;
    cmd(8'hE4, 8'h84, 8'hFF);
    check(n_str, 2);
    check(s_addr, 17'h1ABCD);
    check(s_dat, 8'h5A);
    check(hold_n >= 12, 1);
    wr(efcc_pkg::OFS_DAT, 8'h00);
    cmd(8'hF0, 8'h90, 8'hFF);
    rd(efcc_pkg::OFS_DAT, v);
    check(v, 8'h5A);
    lat = 8'd30;
    wr(efcc_pkg::OFS_CMD, 8'hE4);
    rd(efcc_pkg::OFS_CMD, v);
    check(v[6], 1'b1);
    wr(efcc_pkg::OFS_DAT, 8'h77);
    fin(8'h84, 8'hFF);
    rd(efcc_pkg::OFS_DAT, v);
    check(v, 8'h5A);
    lat = 8'd6;
    flip = 1'b1;
    cmd(8'hE4, 8'h00, 8'hC0);
    flip = 1'b0;
    cmd(8'hF0, 8'h90, 8'hFF);
    $display("test write done");
  endtask
  task automatic t_erase();
    adr(17'h0C3FF);
    wr(efcc_pkg::OFS_DAT, 8'h11);
    cmd(8'hE4, 8'h84, 8'hFF);
    adr(17'h0C400);
    wr(efcc_pkg::OFS_DAT, 8'h22);
    cmd(8'hE4, 8'h84, 8'hFF);
    adr(17'h0C123);
    cmd(8'hE8, 8'h88, 8'hFF);
    check(s_addr, 17'h0C000);
    adr(17'h0C3FF);
    cmd(8'hF0, 8'h90, 8'hFF);
    rd(efcc_pkg::OFS_DAT, v);
    check(v, 8'hFF);
    adr(17'h0C400);
    cmd(8'hF0, 8'h90, 8'hFF);
    rd(efcc_pkg::OFS_DAT, v);
    check(v, 8'h22);
    $display("test erase done");
  endtask
  task automatic t_codes();
    logic [4:0] bad [5] = '{5'h03, 5'h12, 5'h00, 5'h11, 5'h18};
    for (int i = 0; i < 5; i++)
    begin
      n_str = 0;
      cmd({3'h7, bad[i]}, {3'h5, bad[i]}, 8'hFF);
      check(n_str, 0);
    end
    rd(efcc_pkg::OFS_CMD, v);
    check(v[5], 1'b1);
    cmd(8'hF0, 8'h90, 8'hFF);
    $display("test codes done");
  endtask
  task automatic t_ifb();
    adr(17'h00010);
    wr(efcc_pkg::OFS_DAT, 8'h3C);
    cmd(8'hE1, 8'h81, 8'hFF);
    cmd(8'hE2, 8'h82, 8'hFF);
    rd(efcc_pkg::OFS_DAT, v);
    check(v, 8'h3C);
    adr(17'h000F0);
    cmd(8'hE1, 8'hA1, 8'hFF);
    wm = 1'b1;
    repeat (4) @(negedge mclk_i);
    cmd(8'hE1, 8'h81, 8'hFF);
    wm = 1'b0;
    adr(17'h00100);
    cmd(8'hE2, 8'hA2, 8'hFF);
    $display("test information block done");
  endtask
  task automatic t_zone();
    logic [16:0] za [4] = '{17'h00200, 17'h00400, 17'h1FA00, 17'h1FC00};
    logic [7:0] ze [4] = '{8'hA4, 8'h84, 8'h84, 8'hA4};
    wr(efcc_pkg::OFS_LOZ, 8'h02);
    wr(efcc_pkg::OFS_HIZ, 8'hFD);
    for (int i = 0; i < 4; i++)
    begin
      adr(za[i]);
      cmd(8'hE4, ze[i], 8'hFF);
    end
    $display("test zones done");
  endtask
  task automatic t_timeout();
    // An open unit, so the write reaches the macro and has to time out.
    adr(17'h00400);
    mute = 1'b1;
    cmd(8'h04, 8'h20, 8'h60);
    check(hold_n >= 55 && hold_n <= 60, 1);
    wr(efcc_pkg::OFS_SCL, 8'h7F);
    cmd(8'h04, 8'h20, 8'h60);
    check(hold_n >= 110 && hold_n <= 116, 1);
    // Slowest scaler: one tick in 256 clocks, a divide form would hang.
    wr(efcc_pkg::OFS_SCL, 8'h00);
    cmd(8'h04, 8'h20, 8'h60);
    check(hold_n >= 13829 && hold_n <= 14084, 1);
    mute = 1'b0;
    $display("test timeout done");
  endtask
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", n_checks, fails);
    if (fails == 0 && n_checks > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  initial
  begin
    repeat (12) @(negedge mclk_i);
    rst_n_i = 1'b1;
    repeat (4) @(negedge mclk_i);
    t_reset();
    t_write();
    t_erase();
    t_codes();
    t_ifb();
    t_zone();
    t_timeout();
    end_of_test();
  end
  initial
  begin
    // Every test together needs well under this many cycles.
    repeat (30000) @(posedge mclk_i);
    fails++;
    end_of_test();
  end
endmodule
